// file: design/peripheral_soft_reset_ctrl.sv
// APB register block that drives the software resets of the on-chip peripherals.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl #(
    parameter int ADDR_W = 12,
    parameter int HOLD   = soft_reset_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Capability masks, set for each peripheral that is present
    input  wire logic [31:0]           capabilities_two,
    input  wire logic [31:0]           capabilities_four,
    // Peripheral resets, active high
    output soft_reset_pkg::periph_reset_t periph_reset
);

    // Refused at elaboration, so a bad setting never reaches a netlist.
    if (ADDR_W < 8 || ADDR_W > 32) begin : gen_bad_addr_w
        $error("peripheral_soft_reset_ctrl needs ADDR_W between 8 and 32");
    end
    if (HOLD < 1) begin : gen_bad_hold
        $error("peripheral_soft_reset_ctrl needs HOLD of at least one");
    end

    // Bits that exist in the first reset register.
    localparam logic [31:0] PERIPH_B_FIELDS =
        (32'h0000_0001 << soft_reset_pkg::COMPARATOR_ZERO_BIT)   |
        (32'h0000_0001 << soft_reset_pkg::TIMER_TWO_BIT)         |
        (32'h0000_0001 << soft_reset_pkg::TIMER_ONE_BIT)         |
        (32'h0000_0001 << soft_reset_pkg::TIMER_ZERO_BIT)        |
        (32'h0000_0001 << soft_reset_pkg::SYNC_SERIAL_ZERO_BIT)  |
        (32'h0000_0001 << soft_reset_pkg::ASYNC_SERIAL_ONE_BIT)  |
        (32'h0000_0001 << soft_reset_pkg::ASYNC_SERIAL_ZERO_BIT);

    // Bits that exist in the port reset register.
    localparam logic [31:0] PORT_FIELDS =
        (32'h0000_0001 << soft_reset_pkg::PORT_E_BIT) |
        (32'h0000_0001 << soft_reset_pkg::PORT_D_BIT) |
        (32'h0000_0001 << soft_reset_pkg::PORT_C_BIT) |
        (32'h0000_0001 << soft_reset_pkg::PORT_B_BIT) |
        (32'h0000_0001 << soft_reset_pkg::PORT_A_BIT);

    // Maps a byte address to a register; misaligned or unknown addresses select nothing.
    function automatic soft_reset_pkg::reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
        logic [31:0] full;
        full = 32'(addr);
        if (full[1:0] != 2'h0) begin
            decode_reg = soft_reset_pkg::SEL_NONE;
        end else if (full == 32'(soft_reset_pkg::PERIPH_RESET_B_OFFSET)) begin
            decode_reg = soft_reset_pkg::SEL_PERIPH_B;
        end else if (full == 32'(soft_reset_pkg::PORT_RESET_OFFSET)) begin
            decode_reg = soft_reset_pkg::SEL_PORT;
        end else if (full == 32'(soft_reset_pkg::RESET_STATUS_OFFSET)) begin
            decode_reg = soft_reset_pkg::SEL_STATUS;
        end else if (full == 32'(soft_reset_pkg::CAP_TWO_VIEW_OFFSET)) begin
            decode_reg = soft_reset_pkg::SEL_CAP_TWO;
        end else if (full == 32'(soft_reset_pkg::CAP_FOUR_VIEW_OFFSET)) begin
            decode_reg = soft_reset_pkg::SEL_CAP_FOUR;
        end else begin
            decode_reg = soft_reset_pkg::SEL_NONE;
        end
    endfunction

    // Expands byte strobes into a bit mask.
    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        logic [31:0] mask;
        mask = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            mask[b*8 +: 8] = {8{strb[b]}};
        end
        strobe_mask = mask;
    endfunction

    // Merges write data into a register under a mask of writable bits.
    function automatic logic [31:0] masked_write(input logic [31:0] old_value,
                                                 input logic [31:0] data,
                                                 input logic [31:0] mask);
        masked_write = (old_value & ~mask) | (data & mask);
    endfunction

    // Gathers the per-peripheral requests from both registers.
    function automatic soft_reset_pkg::periph_reset_t to_request(input logic [31:0] ctrl_b,
                                                                  input logic [31:0] ports);
        soft_reset_pkg::periph_reset_t req;
        req.comparator_zero_reset   = ctrl_b[soft_reset_pkg::COMPARATOR_ZERO_BIT];
        req.timer_two_reset         = ctrl_b[soft_reset_pkg::TIMER_TWO_BIT];
        req.timer_one_reset         = ctrl_b[soft_reset_pkg::TIMER_ONE_BIT];
        req.timer_zero_reset        = ctrl_b[soft_reset_pkg::TIMER_ZERO_BIT];
        req.sync_serial_zero_reset  = ctrl_b[soft_reset_pkg::SYNC_SERIAL_ZERO_BIT];
        req.async_serial_one_reset  = ctrl_b[soft_reset_pkg::ASYNC_SERIAL_ONE_BIT];
        req.async_serial_zero_reset = ctrl_b[soft_reset_pkg::ASYNC_SERIAL_ZERO_BIT];
        req.port_e_reset            = ports[soft_reset_pkg::PORT_E_BIT];
        req.port_d_reset            = ports[soft_reset_pkg::PORT_D_BIT];
        req.port_c_reset            = ports[soft_reset_pkg::PORT_C_BIT];
        req.port_b_reset            = ports[soft_reset_pkg::PORT_B_BIT];
        req.port_a_reset            = ports[soft_reset_pkg::PORT_A_BIT];
        to_request = req;
    endfunction

    soft_reset_pkg::ctrl_state_t   state;
    soft_reset_pkg::ctrl_state_t   next_state;
    soft_reset_pkg::periph_reset_t request;
    soft_reset_pkg::periph_reset_t active;
    soft_reset_pkg::reg_sel_t      sel;
    logic [31:0]                   write_mask_b;
    logic [31:0]                   write_mask_port;
    logic [31:0]                   read_value;
    logic                          access;

    assign sel     = decode_reg(paddr);
    assign access  = psel && penable;
    assign request = to_request(state.peripheral_reset_ctrl_b, state.port_reset_ctrl);

    // Absent peripherals have their capability bit clear, so their control bit can never be set.
    assign write_mask_b    = PERIPH_B_FIELDS & capabilities_two & strobe_mask(pstrb);
    assign write_mask_port = PORT_FIELDS & capabilities_four & strobe_mask(pstrb);

    // Read data; undefined bits of the two reset registers are never stored, so they read zero; the capability views return their inputs whole.
    always_comb begin
        read_value = 32'h0000_0000;
        case (sel)
            soft_reset_pkg::SEL_PERIPH_B: begin
                read_value = state.peripheral_reset_ctrl_b & PERIPH_B_FIELDS;
            end
            soft_reset_pkg::SEL_PORT: begin
                read_value = state.port_reset_ctrl & PORT_FIELDS;
            end
            soft_reset_pkg::SEL_STATUS: begin
                read_value = 32'(active);
            end
            soft_reset_pkg::SEL_CAP_TWO: begin
                read_value = capabilities_two;
            end
            soft_reset_pkg::SEL_CAP_FOUR: begin
                read_value = capabilities_four;
            end
            default: begin
                read_value = 32'h0000_0000;
            end
        endcase
    end

    // Every access phase takes two cycles: the first prepares the answer, the second
    // commits it. Registering the answer keeps prdata, pready and pslverr glitch free
    // at the cost of one wait state.
    always_comb begin
        next_state = state;
        case (state.bus)
            soft_reset_pkg::BUS_IDLE: begin
                next_state.pready  = 1'b0;
                next_state.pslverr = 1'b0;
                if (access) begin
                    next_state.bus     = soft_reset_pkg::BUS_ANSWER;
                    next_state.pready  = 1'b1;
                    next_state.pslverr = (sel == soft_reset_pkg::SEL_NONE);
                    next_state.prdata  = pwrite ? 32'h0000_0000 : read_value;
                end
            end
            soft_reset_pkg::BUS_ANSWER: begin
                next_state.bus     = soft_reset_pkg::BUS_IDLE;
                next_state.pready  = 1'b0;
                next_state.pslverr = 1'b0;
                next_state.prdata  = 32'h0000_0000;
                if (access && pwrite) begin
                    if (sel == soft_reset_pkg::SEL_PERIPH_B) begin
                        next_state.peripheral_reset_ctrl_b =
                            masked_write(state.peripheral_reset_ctrl_b, pwdata, write_mask_b);
                    end else if (sel == soft_reset_pkg::SEL_PORT) begin
                        next_state.port_reset_ctrl =
                            masked_write(state.port_reset_ctrl, pwdata, write_mask_port);
                    end
                end
            end
            default: begin
                next_state.bus = soft_reset_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.bus                     <= soft_reset_pkg::BUS_IDLE;
            state.peripheral_reset_ctrl_b <= soft_reset_pkg::PERIPH_RESET_B_RESET;
            state.port_reset_ctrl         <= soft_reset_pkg::PORT_RESET_RESET;
            state.prdata                  <= 32'h0000_0000;
            state.pready                  <= 1'b0;
            state.pslverr                 <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Peripherals stay in reset while their bit is set, and for at least HOLD cycles once raised, even if it clears sooner.
    reset_hold_stage #(
        .WIDTH (soft_reset_pkg::RESET_LINES),
        .HOLD  (HOLD)
    ) u_hold (
        .pclk         (pclk),
        .presetn      (presetn),
        .request      (request),
        .reset_active (active)
    );

    assign prdata       = state.prdata;
    assign pready       = state.pready;
    assign pslverr      = state.pslverr;
    assign periph_reset = active;

endmodule // peripheral_soft_reset_ctrl

// file: design/soft_reset_pkg.sv
// Constants and types shared by the peripheral software reset controller.
package soft_reset_pkg;

    // Register byte offsets.
    localparam logic [11:0] PERIPH_RESET_B_OFFSET = 12'h044;
    localparam logic [11:0] PORT_RESET_OFFSET     = 12'h048;
    localparam logic [11:0] RESET_STATUS_OFFSET   = 12'h04C;
    localparam logic [11:0] CAP_TWO_VIEW_OFFSET   = 12'h050;
    localparam logic [11:0] CAP_FOUR_VIEW_OFFSET  = 12'h054;

    // Field positions in the first reset register.
    localparam int COMPARATOR_ZERO_BIT  = 24;
    localparam int TIMER_TWO_BIT        = 18;
    localparam int TIMER_ONE_BIT        = 17;
    localparam int TIMER_ZERO_BIT       = 16;
    localparam int SYNC_SERIAL_ZERO_BIT = 4;
    localparam int ASYNC_SERIAL_ONE_BIT = 1;
    localparam int ASYNC_SERIAL_ZERO_BIT = 0;

    // Field positions in the port reset register.
    localparam int PORT_E_BIT = 4;
    localparam int PORT_D_BIT = 3;
    localparam int PORT_C_BIT = 2;
    localparam int PORT_B_BIT = 1;
    localparam int PORT_A_BIT = 0;

    // Reset values.
    localparam logic [31:0] PERIPH_RESET_B_RESET = 32'h0000_0000;
    localparam logic [31:0] PORT_RESET_RESET     = 32'h0000_0000;

    // Least number of cycles a peripheral reset stays asserted once raised.
    localparam int RESET_HOLD_CYCLES = 4;

    // Number of peripheral reset lines.
    localparam int RESET_LINES = 12;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PERIPH_B,
        SEL_PORT,
        SEL_STATUS,
        SEL_CAP_TWO,
        SEL_CAP_FOUR
    } reg_sel_t;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

    // One reset request per peripheral, active high.
    typedef struct packed {
        logic comparator_zero_reset;
        logic timer_two_reset;
        logic timer_one_reset;
        logic timer_zero_reset;
        logic sync_serial_zero_reset;
        logic async_serial_one_reset;
        logic async_serial_zero_reset;
        logic port_e_reset;
        logic port_d_reset;
        logic port_c_reset;
        logic port_b_reset;
        logic port_a_reset;
    } periph_reset_t;

    typedef struct packed {
        bus_state_t  bus;
        logic [31:0] peripheral_reset_ctrl_b;
        logic [31:0] port_reset_ctrl;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ctrl_state_t;

endpackage

// file: design/reset_hold_stage.sv
// Registered reset drivers that stretch every raised reset to a least length.
`timescale 1ns/1ps
module reset_hold_stage #(
    parameter int WIDTH = soft_reset_pkg::RESET_LINES,
    parameter int HOLD  = soft_reset_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Requests from the control registers
    input  wire logic [WIDTH-1:0] request,
    // Reset levels to the peripherals, active high
    output logic      [WIDTH-1:0] reset_active
);

    localparam int CNT_W = $clog2(HOLD + 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD - 1);

    if (WIDTH < 1 || HOLD < 1) begin : gen_bad_params
        $error("reset_hold_stage needs WIDTH and HOLD of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0]            active;
        logic [WIDTH-1:0][CNT_W-1:0] hold;
    } hold_state_t;

    hold_state_t state;
    hold_state_t next_state;

    // A short pulse on a control bit still gives the peripheral a clean reset.
    always_comb begin
        next_state = state;
        for (int i = 0; i < WIDTH; i++) begin
            if (request[i] && !state.active[i]) begin
                next_state.hold[i] = HOLD_LOAD;
            end else if (state.hold[i] != '0) begin
                next_state.hold[i] = state.hold[i] - CNT_W'(1);
            end
            next_state.active[i] = request[i] || (state.hold[i] != '0) || (request[i] && !state.active[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reset_active = state.active;

endmodule // reset_hold_stage

// file: testbench/soft_reset_checker.sv
// Concurrent checks on the ports of the peripheral software reset controller.
`timescale 1ns/1ps
module soft_reset_checker #(
    parameter int ADDR_W = 12,
    parameter int HOLD   = 4
) (
    // Clock and reset
    input logic                          pclk,
    input logic                          presetn,
    // APB slave
    input logic                          psel,
    input logic                          penable,
    input logic                          pwrite,
    input logic [ADDR_W-1:0]             paddr,
    input logic [31:0]                   pwdata,
    input logic [3:0]                    pstrb,
    input logic [31:0]                   prdata,
    input logic                          pready,
    input logic                          pslverr,
    // Capabilities and resets
    input logic [31:0]                   capabilities_two,
    input logic [31:0]                   capabilities_four,
    input soft_reset_pkg::periph_reset_t periph_reset
);
    localparam logic [31:0] FIELD_B = 32'h0107_0013;
    // The hold check below counts four cycles, so it only serves the default hold.
    if (HOLD != 4) begin : gen_hold_fixed
        $error("soft_reset_checker expects HOLD of four");
    end
    logic [31:0] seen_b, seen_p, lanes, set_b, set_p, blk_b, blk_p;
    logic        done, wr_b, wr_p, mapped;
    assign seen_b = {7'h00, periph_reset[11], 5'h00, periph_reset[10:8], 11'h000, periph_reset[7], 2'h0, periph_reset[6:5]};
    assign seen_p = {27'h0000000, periph_reset[4:0]};
    assign lanes  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign done   = psel && penable && pready && pwrite && !pslverr;
    assign wr_b   = done && paddr == 12'h044;
    assign wr_p   = done && paddr == 12'h048;
    assign set_b  = FIELD_B & capabilities_two & pwdata & lanes;
    assign set_p  = 32'h0000_001F & capabilities_four & pwdata & lanes;
    assign blk_b  = FIELD_B & ~seen_b & ~set_b;
    assign blk_p  = 32'h0000_001F & ~seen_p & ~set_p;
    assign mapped = paddr inside {12'h044, 12'h048, 12'h04C, 12'h050, 12'h054};

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready held past one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without a held access phase");
    AST_IDLE_QUIET: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus outputs not idle");
    AST_REFUSE: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_RSV_ZERO: assert property (pready && !pwrite |-> (paddr != 12'h044 || (prdata & ~FIELD_B) == 32'h0)
        && (paddr != 12'h048 || prdata[31:5] == 27'h0)) else $error("unused bits read nonzero");
    AST_B_SET: assert property (wr_b |-> ##2 (seen_b & $past(set_b, 2)) == $past(set_b, 2))
        else $error("enabled reset line did not rise");
    AST_B_BLOCK: assert property (wr_b |-> ##2 (seen_b & $past(blk_b, 2)) == 32'h0)
        else $error("masked reset line rose");
    AST_P_SET: assert property (wr_p |-> ##2 (seen_p & $past(set_p, 2)) == $past(set_p, 2))
        else $error("enabled port reset did not rise");
    AST_P_BLOCK: assert property (wr_p |-> ##2 (seen_p & $past(blk_p, 2)) == 32'h0)
        else $error("masked port reset rose");
    // The repeat count stands for the default HOLD of four cycles.
    AST_HOLD_MIN: assert property ($rose(periph_reset.port_a_reset) |-> periph_reset.port_a_reset [*4])
        else $error("reset pulse shorter than hold");
    AST_RESET_CLEAR: assert property ($rose(presetn) |-> periph_reset == 12'h000 && !pready)
        else $error("outputs not clear after reset");
endmodule // soft_reset_checker

bind peripheral_soft_reset_ctrl soft_reset_checker #(.ADDR_W(ADDR_W), .HOLD(HOLD)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capabilities_two(capabilities_two), .capabilities_four(capabilities_four), .periph_reset(periph_reset));

// file: testbench/peripheral_soft_reset_ctrl_tb.sv
// Self-checking bench for the peripheral software reset controller.
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, capabilities_two, capabilities_four, rd;
    logic [3:0]  pstrb;
    int          n_mismatch, compares, cycles;
    int          b_bits[7] = '{24, 18, 17, 16, 4, 1, 0};
    soft_reset_pkg::periph_reset_t periph_reset;

    peripheral_soft_reset_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capabilities_two(capabilities_two), .capabilities_four(capabilities_four), .periph_reset(periph_reset));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] as_b(input logic [11:0] v);
        return {7'h00, v[11], 5'h00, v[10:8], 11'h000, v[7], 2'h0, v[6:5]};
    endfunction

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One APB transfer; an idle edge first keeps release and the next setup apart.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sets one field alone, then checks the reset lines and the read back.
    task automatic field(input logic [11:0] a, input int b);
        apb(1'b1, a, 32'h1 << b, 4'hF);
        repeat (2) @(posedge pclk);
        check("reset lines", a == 12'h044 ? as_b(periph_reset) : 32'(periph_reset[4:0]), 32'h1 << b);
        apb(1'b0, a, 32'h0, 4'hF);
        check("field readback", rd, 32'h1 << b);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        capabilities_two = 32'hFFFF_FFFF;
        capabilities_four = 32'hFFFF_FFFF;
        presetn = 1'b0;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("first reset value", rd, 32'h0);
        apb(1'b0, 12'h048, 32'h0, 4'hF);
        check("port reset value", rd, 32'h0);
        foreach (b_bits[i]) field(12'h044, b_bits[i]);
        for (int k = 0; k < 5; k++) field(12'h048, k);
        apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, 12'h048, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("first unused bits", rd, 32'h0107_0013);
        apb(1'b0, 12'h048, 32'h0, 4'hF);
        check("port unused bits", rd, 32'h0000_001F);
        check("all lines", 32'(periph_reset), 32'h0000_0FFF);
        apb(1'b0, 12'h04C, 32'h0, 4'hF);
        check("status view", rd, 32'h0000_0FFF);
        apb(1'b1, 12'h044, 32'h0, 4'hF);
        apb(1'b1, 12'h048, 32'h0, 4'hF);
        repeat (6) @(posedge pclk);
        check("released lines", 32'(periph_reset), 32'h0);
        // Masked capabilities: only timer zero, async serial zero, ports A and C present.
        capabilities_two <= 32'h0001_0001;
        capabilities_four <= 32'h0000_0005;
        apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, 12'h048, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("masked first", rd, 32'h0001_0001);
        apb(1'b0, 12'h048, 32'h0, 4'hF);
        check("masked port", rd, 32'h0000_0005);
        check("masked lines", 32'(periph_reset), 32'h0000_0125);
        apb(1'b0, 12'h050, 32'h0, 4'hF);
        check("capability view", rd, 32'h0001_0001);
        apb(1'b0, 12'h054, 32'h0, 4'hF);
        check("port capability view", rd, 32'h0000_0005);
        apb(1'b1, 12'h050, 32'h0, 4'hF);
        check("view write error", 32'(err), 32'h0);
        apb(1'b1, 12'h044, 32'h0, 4'hF);
        capabilities_two <= 32'hFFFF_FFFF;
        apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'h8);
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("strobe lane", rd, 32'h0100_0000);
        apb(1'b0, 12'h058, 32'h0, 4'hF);
        check("unmapped error", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 12'h045, 32'hFFFF_FFFF, 4'hF);
        check("misaligned error", 32'(err), 32'h1);
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("misaligned no effect", rd, 32'h0100_0000);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("lines after reset", 32'(periph_reset), 32'h0);
        apb(1'b0, 12'h044, 32'h0, 4'hF);
        check("first after reset", rd, 32'h0);
        close_out();
    end
endmodule // peripheral_soft_reset_ctrl_tb
